// [btc_area_chk.sv]
`timescale 1ns/1ns
`include "btc_consts.svh"

module btc_area_chk import btc_pkg::*; (
  // Run bounds
  input  wire logic [`BTC_AW-1:0] first_i,
  input  wire logic [`BTC_AW:0]   last_i,
  // Verdict
  output logic                    same_o
);

  // -------------------------------------------------------------------------
  // Area lookup
  // -------------------------------------------------------------------------
  function automatic btc_area_type area_of(input logic [`BTC_AW:0] a);
    btc_area_type id;
    id = 3'h7;
    if (a >= `BTC_IR_LO && a <= `BTC_IR_HI) id = 3'h0;
    if (a >= `BTC_HR_LO && a <= `BTC_HR_HI) id = 3'h1;
    if (a >= `BTC_AR_LO && a <= `BTC_AR_HI) id = 3'h2;
    if (a >= `BTC_LR_LO && a <= `BTC_LR_HI) id = 3'h3;
    if (a >= `BTC_TC_LO && a <= `BTC_TC_HI) id = 3'h4;
    if (a >= `BTC_DM_LO && a <= `BTC_DM_HI) id = 3'h5;
    return id;
  endfunction : area_of

  btc_area_type first_id;
  btc_area_type last_id;

  assign first_id = area_of({1'b0, first_i});
  assign last_id  = area_of(last_i);
  // Unmapped words never count as an area, so a run touching a hole fails
  assign same_o   = (first_id == last_id) && (first_id != 3'h7);

endmodule : btc_area_chk

// [btc_consts.svh]
`ifndef BTC_CONSTS_SVH
`define BTC_CONSTS_SVH

// ---------------------------------------------------------------------------
// Word and address widths
// ---------------------------------------------------------------------------
`define BTC_AW           12
`define BTC_DW           16

// ---------------------------------------------------------------------------
// Control word fields of the bit-field transfer
// ---------------------------------------------------------------------------
`define BTC_CTL_SBIT     3:0
`define BTC_CTL_DBIT     7:4
`define BTC_CTL_CNT      15:8

// ---------------------------------------------------------------------------
// Data area map (inclusive word address bounds)
// ---------------------------------------------------------------------------
`define BTC_IR_LO        13'h0000
`define BTC_IR_HI        13'h01FF
`define BTC_HR_LO        13'h0200
`define BTC_HR_HI        13'h027F
`define BTC_AR_LO        13'h0280
`define BTC_AR_HI        13'h02FF
`define BTC_LR_LO        13'h0300
`define BTC_LR_HI        13'h033F
`define BTC_TC_LO        13'h0400
`define BTC_TC_HI        13'h07FF
`define BTC_DM_LO        13'h0800
`define BTC_DM_HI        13'h0BFF

// ---------------------------------------------------------------------------
// Indirect data-memory references
// ---------------------------------------------------------------------------
`define BTC_DM_BASE      12'h800
`define BTC_DM_WORDS     14'h0400
`define BTC_BCD_MAX      4'h9
`define BTC_W1000        14'h03E8
`define BTC_W100         14'h0064
`define BTC_W10          14'h000A

// ---------------------------------------------------------------------------
// Compare table geometry
// ---------------------------------------------------------------------------
`define BTC_TBL_LAST     4'hF
`define BTC_TBL_SPAN     13'h000F

`endif

// [btc_core.sv]
// Behaviour
// - With the execution condition off, a bit-field transfer request does nothing at all.
// - With the condition on, the chosen source bits are copied in order to the destination bits.
// - Control word digit 0 is the source start bit and digit 1 the destination start bit.
// - Control word digits 2 and 3 give the bit count, and runs may cross into following words.
// - A source run not wholly inside one data area raises the error flag.
// - A destination run not wholly inside one data area raises the error flag.
// - An indirect pointer that is not BCD or leaves data memory raises the error flag.
// - With the execution condition off, a compare request leaves the result word alone.
// - With the condition on, word k of table one is compared to word k of table two, k 0 to 15.
// - An equal pair k clears result bit k, offset zero being bit 0.
// - A differing pair sets its result bit.
// - A table whose sixteen words leave its data area raises the error flag.
`timescale 1ns/1ns
`include "btc_consts.svh"

module btc_core import btc_pkg::*; (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                sys_rst_i,
  // Instruction requests
  input  wire logic                exec_cond_i,
  input  wire logic                xfer_go_i,
  input  wire logic                cmp_go_i,
  input  wire logic [`BTC_DW-1:0]  ctl_word_i,
  // Operand A: source or first table
  input  wire logic [`BTC_AW-1:0]  opa_addr_i,
  input  wire logic                opa_ind_i,
  input  wire logic [`BTC_DW-1:0]  opa_ptr_i,
  // Operand B: destination or second table
  input  wire logic [`BTC_AW-1:0]  opb_addr_i,
  input  wire logic                opb_ind_i,
  input  wire logic [`BTC_DW-1:0]  opb_ptr_i,
  // Operand C: compare result word
  input  wire logic [`BTC_AW-1:0]  opc_addr_i,
  input  wire logic                opc_ind_i,
  input  wire logic [`BTC_DW-1:0]  opc_ptr_i,
  // Word memory
  input  wire logic [`BTC_DW-1:0]  mem_rdata_i,
  output logic      [`BTC_AW-1:0]  mem_addr_o,
  output logic                     mem_rd_o,
  output logic                     mem_wr_o,
  output logic      [`BTC_DW-1:0]  mem_wdata_o,
  // Status
  output logic                     error_flag_o,
  output logic                     busy_o,
  output logic                     done_o
);

  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  btc_state_type      state_ff;
  btc_state_type      nxt_state;

  logic [`BTC_AW-1:0] eff_a;
  logic [`BTC_AW-1:0] eff_b;
  logic [`BTC_AW-1:0] eff_c;
  logic               bad_a;
  logic               bad_b;
  logic               bad_c;
  logic               same_a;
  logic               same_b;

  logic [3:0]         ctl_sbit;
  logic [3:0]         ctl_dbit;
  logic [7:0]         ctl_cnt;
  logic [8:0]         run_s;
  logic [8:0]         run_d;
  logic [`BTC_AW:0]   xlast_a;
  logic [`BTC_AW:0]   xlast_b;
  logic [`BTC_AW:0]   clast_a;
  logic [`BTC_AW:0]   clast_b;
  logic [`BTC_AW:0]   last_a;
  logic [`BTC_AW:0]   last_b;

  logic               xfer_req;
  logic               cmp_req;
  logic               xfer_err;
  logic               cmp_err;
  logic               start_err;

  logic [`BTC_AW-1:0] base_a_ff;
  logic [`BTC_AW-1:0] base_b_ff;
  logic [`BTC_AW-1:0] base_c_ff;
  logic [8:0]         src_pos_ff;
  logic [8:0]         dst_pos_ff;
  logic [7:0]         rem_ff;
  logic               src_bit_ff;
  logic [3:0]         idx_ff;
  logic [`BTC_DW-1:0] a_word_ff;
  logic [`BTC_DW-1:0] result_ff;
  logic [`BTC_DW-1:0] dst_mask;

  logic [`BTC_AW-1:0] mem_addr_ff;
  logic               mem_rd_ff;
  logic               mem_wr_ff;
  logic [`BTC_DW-1:0] mem_wdata_ff;
  logic               error_ff;
  logic               busy_ff;
  logic               done_ff;

  // -------------------------------------------------------------------------
  // Operand resolution
  // -------------------------------------------------------------------------
  btc_ind_resolve u_ind_a (
    .ind_i  (opa_ind_i),
    .addr_i (opa_addr_i),
    .ptr_i  (opa_ptr_i),
    .addr_o (eff_a),
    .bad_o  (bad_a)
  );

  btc_ind_resolve u_ind_b (
    .ind_i  (opb_ind_i),
    .addr_i (opb_addr_i),
    .ptr_i  (opb_ptr_i),
    .addr_o (eff_b),
    .bad_o  (bad_b)
  );

  btc_ind_resolve u_ind_c (
    .ind_i  (opc_ind_i),
    .addr_i (opc_addr_i),
    .ptr_i  (opc_ptr_i),
    .addr_o (eff_c),
    .bad_o  (bad_c)
  );

  // -------------------------------------------------------------------------
  // Run extents and area checks
  // -------------------------------------------------------------------------
  assign ctl_sbit = ctl_word_i[`BTC_CTL_SBIT];
  assign ctl_dbit = ctl_word_i[`BTC_CTL_DBIT];
  assign ctl_cnt  = ctl_word_i[`BTC_CTL_CNT];

  // Index of the last bit moved, counted from bit 0 of the start word
  assign run_s = (ctl_cnt == 8'h00) ? 9'h000 : ({5'h00, ctl_sbit} + {1'b0, ctl_cnt} - 9'h001);
  assign run_d = (ctl_cnt == 8'h00) ? 9'h000 : ({5'h00, ctl_dbit} + {1'b0, ctl_cnt} - 9'h001);

  assign xlast_a = {1'b0, eff_a} + {8'h00, run_s[8:4]};
  assign xlast_b = {1'b0, eff_b} + {8'h00, run_d[8:4]};
  assign clast_a = {1'b0, eff_a} + `BTC_TBL_SPAN;
  assign clast_b = {1'b0, eff_b} + `BTC_TBL_SPAN;

  // Transfer wins the shared checkers if both requests arrive together
  assign last_a = xfer_go_i ? xlast_a : clast_a;
  assign last_b = xfer_go_i ? xlast_b : clast_b;

  btc_area_chk u_area_a (
    .first_i (eff_a),
    .last_i  (last_a),
    .same_o  (same_a)
  );

  btc_area_chk u_area_b (
    .first_i (eff_b),
    .last_i  (last_b),
    .same_o  (same_b)
  );

  // -------------------------------------------------------------------------
  // Request decode
  // -------------------------------------------------------------------------
  assign xfer_req  = (state_ff == BTC_IDLE) && exec_cond_i && xfer_go_i;
  assign cmp_req   = (state_ff == BTC_IDLE) && exec_cond_i && cmp_go_i && !xfer_go_i;
  assign xfer_err  = bad_a || bad_b || !same_a || !same_b;
  assign cmp_err   = bad_a || bad_b || bad_c || !same_a || !same_b;
  assign start_err = (xfer_req && xfer_err) || (cmp_req && cmp_err);

  // -------------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BTC_IDLE: begin
        if (xfer_req && !xfer_err) begin
          nxt_state = (ctl_cnt == 8'h00) ? BTC_DONE : BTC_XRS;
        end else if (cmp_req && !cmp_err) begin
          nxt_state = BTC_CRA;
        end
      end
      BTC_XRS:  nxt_state = BTC_XRD;
      BTC_XRD:  nxt_state = BTC_XWR;
      BTC_XWR:  nxt_state = (rem_ff == 8'h01) ? BTC_DONE : BTC_XRS;
      BTC_CRA:  nxt_state = BTC_CRB;
      BTC_CRB:  nxt_state = BTC_CCM;
      BTC_CCM:  nxt_state = (idx_ff == `BTC_TBL_LAST) ? BTC_CWR : BTC_CRA;
      BTC_CWR:  nxt_state = BTC_DONE;
      BTC_DONE: nxt_state = BTC_IDLE;
      default:  nxt_state = BTC_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= BTC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // -------------------------------------------------------------------------
  // Operand latches
  // -------------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      base_a_ff <= 12'h000;
      base_b_ff <= 12'h000;
      base_c_ff <= 12'h000;
    end else if (state_ff == BTC_IDLE && nxt_state != BTC_IDLE) begin
      base_a_ff <= eff_a;
      base_b_ff <= eff_b;
      base_c_ff <= eff_c;
    end
  end

  // -------------------------------------------------------------------------
  // Bit-field transfer counters
  // -------------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_pos_ff <= 9'h000;
      dst_pos_ff <= 9'h000;
      rem_ff     <= 8'h00;
      src_bit_ff <= 1'b0;
    end else begin
      if (xfer_req && !xfer_err) begin
        src_pos_ff <= {5'h00, ctl_sbit};
        dst_pos_ff <= {5'h00, ctl_dbit};
        rem_ff     <= ctl_cnt;
      end
      if (state_ff == BTC_XRD) begin
        src_bit_ff <= mem_rdata_i[src_pos_ff[3:0]];
      end
      // Both positions advance together, which keeps the bit order
      if (state_ff == BTC_XWR) begin
        src_pos_ff <= src_pos_ff + 9'h001;
        dst_pos_ff <= dst_pos_ff + 9'h001;
        rem_ff     <= rem_ff - 8'h01;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Table compare datapath
  // -------------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idx_ff    <= 4'h0;
      a_word_ff <= 16'h0000;
      result_ff <= 16'h0000;
    end else begin
      if (cmp_req && !cmp_err) begin
        idx_ff <= 4'h0;
      end
      if (state_ff == BTC_CRB) begin
        a_word_ff <= mem_rdata_i;
      end
      if (state_ff == BTC_CCM) begin
        result_ff[idx_ff] <= (a_word_ff != mem_rdata_i);
        idx_ff            <= idx_ff + 4'h1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Memory port
  // -------------------------------------------------------------------------
  assign dst_mask = 16'h0001 << dst_pos_ff[3:0];

  // Read data is taken in the cycle the strobe is visible; a write to a word
  // lands before the next bit's source read, so overlapping runs stay sane.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_addr_ff  <= 12'h000;
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b0;
      mem_wdata_ff <= 16'h0000;
    end else begin
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      case (state_ff)
        BTC_XRS: begin
          mem_addr_ff <= base_a_ff + {7'h00, src_pos_ff[8:4]};
          mem_rd_ff   <= 1'b1;
        end
        BTC_XRD: begin
          mem_addr_ff <= base_b_ff + {7'h00, dst_pos_ff[8:4]};
          mem_rd_ff   <= 1'b1;
        end
        BTC_XWR: begin
          mem_wr_ff    <= 1'b1;
          mem_wdata_ff <= (mem_rdata_i & ~dst_mask) | (src_bit_ff ? dst_mask : 16'h0000);
        end
        BTC_CRA: begin
          mem_addr_ff <= base_a_ff + {8'h00, idx_ff};
          mem_rd_ff   <= 1'b1;
        end
        BTC_CRB: begin
          mem_addr_ff <= base_b_ff + {8'h00, idx_ff};
          mem_rd_ff   <= 1'b1;
        end
        BTC_CWR: begin
          mem_addr_ff  <= base_c_ff;
          mem_wr_ff    <= 1'b1;
          mem_wdata_ff <= result_ff;
        end
        default: begin
          mem_rd_ff <= 1'b0;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Status
  // -------------------------------------------------------------------------
  // An error start never leaves idle, so nothing is ever written for it
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      error_ff <= 1'b0;
    end else if (start_err) begin
      error_ff <= 1'b1;
    end else if (state_ff == BTC_DONE) begin
      error_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != BTC_IDLE);
      done_ff <= start_err || (state_ff == BTC_DONE);
    end
  end

  assign mem_addr_o   = mem_addr_ff;
  assign mem_rd_o     = mem_rd_ff;
  assign mem_wr_o     = mem_wr_ff;
  assign mem_wdata_o  = mem_wdata_ff;
  assign error_flag_o = error_ff;
  assign busy_o       = busy_ff;
  assign done_o       = done_ff;

endmodule : btc_core

// [btc_core_props.sv]
`timescale 1ns/1ns

module btc_core_props import btc_pkg::*; (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  // Requests
  input  wire logic exec_cond_i,
  input  wire logic xfer_go_i,
  input  wire logic cmp_go_i,
  // Design outputs
  input  wire logic mem_rd_o,
  input  wire logic mem_wr_o,
  input  wire logic error_flag_o,
  input  wire logic busy_o,
  input  wire logic done_o
);
  // --------------------
  // Port relations
  // --------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  a_cond_off_idle: assert property (!busy_o && !exec_cond_i |=> !busy_o)
    else $error("operation started with the condition off");
  // The done cycle and the cycle after busy falls are left out, though the sequencer is already idle there
  a_take_starts: assert property (exec_cond_i && (xfer_go_i || cmp_go_i)
    && !busy_o && !done_o && !$past(busy_o) |-> ##[1:2] (busy_o || done_o))
    else $error("accepted request did not start");
  a_err_at_done: assert property ($rose(error_flag_o) |-> done_o && !busy_o)
    else $error("error flag rose outside a finished request");
  a_flag_steady: assert property (!done_o |-> $stable(error_flag_o))
    else $error("error flag changed without a completion");
  a_access_busy: assert property (mem_rd_o || mem_wr_o |-> busy_o)
    else $error("memory accessed outside a running operation");
  a_busy_ends_done: assert property ($fell(busy_o) |-> ##[0:2] done_o)
    else $error("operation ended without a completion pulse");
  a_done_quiet: assert property (done_o |-> !busy_o && !mem_wr_o && !mem_rd_o)
    else $error("completion pulse during activity");
  a_busy_bounded: assert property ($rose(busy_o) |-> ##[2:800] !busy_o)
    else $error("operation ran too long");
endmodule : btc_core_props

bind btc_core btc_core_props btc_core_props_inst (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .exec_cond_i(exec_cond_i),
  .xfer_go_i(xfer_go_i), .cmp_go_i(cmp_go_i), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
  .error_flag_o(error_flag_o), .busy_o(busy_o), .done_o(done_o)
);

// [btc_core_tb_top.sv]
`timescale 1ns/1ns

module btc_core_tb_top;
  // --------------------
  // Signals and memory
  // --------------------
  localparam logic [15:0] CMP_DIFF = 16'h9C78;
  logic        clock_i, sys_rst_i, exec_cond_i, xfer_go_i, cmp_go_i;
  logic        opa_ind_i, opb_ind_i, opc_ind_i, mem_rd_o, mem_wr_o;
  logic        error_flag_o, busy_o, done_o;
  logic [15:0] ctl_word_i, opa_ptr_i, opb_ptr_i, opc_ptr_i, mem_rdata_i, mem_wdata_o;
  logic [11:0] opa_addr_i, opb_addr_i, opc_addr_i, mem_addr_o;
  logic [15:0] mem [0:4095];
  logic [15:0] ref_mem [0:4095];
  int          fails = 0;
  int          tests_run = 0;

  btc_core btc_core_inst (
    .clock_i, .sys_rst_i, .exec_cond_i, .xfer_go_i, .cmp_go_i, .ctl_word_i,
    .opa_addr_i, .opa_ind_i, .opa_ptr_i, .opb_addr_i, .opb_ind_i, .opb_ptr_i,
    .opc_addr_i, .opc_ind_i, .opc_ptr_i, .mem_rdata_i, .mem_addr_o, .mem_rd_o,
    .mem_wr_o, .mem_wdata_o, .error_flag_o, .busy_o, .done_o
  );

  always #50 clock_i = ~clock_i;
  // Asynchronous read, write at the edge that ends the strobe cycle
  assign mem_rdata_i = mem[mem_addr_o];
  always @(posedge clock_i) begin
    if (mem_wr_o) mem[mem_addr_o] <= mem_wdata_o;
  end

  // --------------------
  // Shared tasks
  // --------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_flag

  task automatic sync_ref;
    foreach (mem[i]) ref_mem[i] = mem[i];
  endtask : sync_ref

  task automatic check_mem;
    foreach (mem[i]) check_word(mem[i], ref_mem[i]);
  endtask : check_mem

  // Bit by bit, so runs that straddle words need no special case
  task automatic ref_xfer(input logic [11:0] a, input logic [11:0] b, input logic [15:0] ctl);
    int s;
    int d;
    for (int i = 0; i < ctl[15:8]; i++) begin
      s = ctl[3:0] + i;
      d = ctl[7:4] + i;
      ref_mem[b + d / 16][d % 16] = ref_mem[a + s / 16][s % 16];
    end
  endtask : ref_xfer

  // A missing completion ends the run, since later checks would be meaningless
  task automatic run_op(input logic cond, input logic xf, input logic cm, input logic want);
    int n;
    n = 0;
    @(posedge clock_i);
    #1;
    exec_cond_i = cond;
    xfer_go_i   = xf;
    cmp_go_i    = cm;
    @(posedge clock_i);
    #1;
    xfer_go_i = 1'b0;
    cmp_go_i  = 1'b0;
    while (done_o !== 1'b1 && n < (want ? 1000 : 20)) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    check_flag(done_o, want);
    if (want && done_o !== 1'b1) complete_run();
    @(posedge clock_i);
    #1;
  endtask : run_op

  task automatic do_xfer(input logic [11:0] a, input logic ia, input logic [15:0] pa,
                         input logic [11:0] b, input logic [15:0] ctl,
                         input logic [11:0] ra, input logic err);
    opa_addr_i = a;
    opa_ind_i  = ia;
    opa_ptr_i  = pa;
    opb_addr_i = b;
    ctl_word_i = ctl;
    if (!err) ref_xfer(ra, b, ctl);
    run_op(1'b1, 1'b1, 1'b0, 1'b1);
    check_flag(error_flag_o, err);
  endtask : do_xfer

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_area_errors;
    sync_ref();
    do_xfer(12'h1FF, 1'b0, 16'h0000, 12'h300, 16'h020F, 12'h000, 1'b1);
    do_xfer(12'h020, 1'b0, 16'h0000, 12'h321, 16'h0540, 12'h020, 1'b0);
    do_xfer(12'h020, 1'b0, 16'h0000, 12'h27F, 16'h02F0, 12'h000, 1'b1);
    check_mem();
    $display("area error test finished");
  endtask : t_area_errors

  task automatic t_cond_off;
    sync_ref();
    run_op(1'b0, 1'b1, 1'b0, 1'b0);
    run_op(1'b0, 1'b0, 1'b1, 1'b0);
    check_flag(error_flag_o, 1'b1);
    check_mem();
    $display("condition off test finished");
  endtask : t_cond_off

  task automatic t_xfer;
    sync_ref();
    // A zero count completes cleanly without touching memory
    do_xfer(12'h030, 1'b0, 16'h0000, 12'h040, 16'h0035, 12'h030, 1'b0);
    do_xfer(12'h030, 1'b0, 16'h0000, 12'h040, 16'h14EF, 12'h030, 1'b0);
    do_xfer(12'h050, 1'b0, 16'h0000, 12'h080, 16'hFE00, 12'h050, 1'b0);
    check_mem();
    $display("transfer test finished");
  endtask : t_xfer

  task automatic t_indirect;
    sync_ref();
    do_xfer(12'h000, 1'b1, 16'h00A5, 12'h090, 16'h0300, 12'h000, 1'b1);
    do_xfer(12'h000, 1'b1, 16'h0123, 12'h090, 16'h0352, 12'h87B, 1'b0);
    do_xfer(12'h000, 1'b1, 16'h1024, 12'h090, 16'h0300, 12'h000, 1'b1);
    do_xfer(12'h000, 1'b1, 16'h1023, 12'h091, 16'h03C1, 12'hBFF, 1'b0);
    check_mem();
    $display("indirect test finished");
  endtask : t_indirect

  task automatic t_cmp;
    logic [15:0] a;
    for (int k = 0; k < 16; k++) begin
      a = 16'hA5C3 ^ 16'(k * 16'h0111);
      mem[12'h100 + k] = a;
      mem[12'h820 + k] = CMP_DIFF[k] ? a ^ (16'h0001 << k) : a;
    end
    mem[12'h864] = ~CMP_DIFF;
    sync_ref();
    // The indirect scenario leaves operand A indirect; the tables are direct
    opa_ind_i  = 1'b0;
    opb_ind_i  = 1'b0;
    opb_addr_i = 12'h820;
    opa_addr_i = 12'h1F8;
    opc_ind_i  = 1'b1;
    opc_ptr_i  = 16'h0100;
    run_op(1'b1, 1'b0, 1'b1, 1'b1);
    check_flag(error_flag_o, 1'b1);
    check_word(mem[12'h864], ~CMP_DIFF);
    opa_addr_i = 12'h100;
    run_op(1'b1, 1'b0, 1'b1, 1'b1);
    check_flag(error_flag_o, 1'b0);
    check_word(mem[12'h864], CMP_DIFF);
    opb_addr_i = 12'hBF5;
    run_op(1'b1, 1'b0, 1'b1, 1'b1);
    check_flag(error_flag_o, 1'b1);
    ref_mem[12'h864] = CMP_DIFF;
    check_mem();
    $display("compare test finished");
  endtask : t_cmp

  initial begin
    clock_i     = 1'b0;
    sys_rst_i   = 1'b1;
    exec_cond_i = 1'b0;
    xfer_go_i   = 1'b0;
    cmp_go_i    = 1'b0;
    ctl_word_i  = 16'h0000;
    opa_addr_i  = 12'h000;
    opb_addr_i  = 12'h000;
    opc_addr_i  = 12'h000;
    opa_ind_i   = 1'b0;
    opb_ind_i   = 1'b0;
    opc_ind_i   = 1'b0;
    opa_ptr_i   = 16'h0000;
    opb_ptr_i   = 16'h0000;
    opc_ptr_i   = 16'h0000;
    foreach (mem[i]) mem[i] = 16'(i * 16'h9E37 + 16'h1234);
    repeat (3) @(posedge clock_i);
    #1;
    sys_rst_i = 1'b0;
    t_area_errors();
    t_cond_off();
    t_xfer();
    t_indirect();
    t_cmp();
    complete_run();
  end
endmodule : btc_core_tb_top

// [btc_ind_resolve.sv]
`timescale 1ns/1ns
`include "btc_consts.svh"

module btc_ind_resolve import btc_pkg::*; (
  // Operand as given
  input  wire logic                ind_i,
  input  wire logic [`BTC_AW-1:0]  addr_i,
  input  wire logic [`BTC_DW-1:0]  ptr_i,
  // Resolved operand
  output logic      [`BTC_AW-1:0]  addr_o,
  output logic                     bad_o
);

  logic [3:0]  digit_ok;
  logic [13:0] ptr_bin;

  genvar g;
  for (g = 0; g < 4; g++) begin : g_dig
    assign digit_ok[g] = (ptr_i[4*g+3 -: 4] <= `BTC_BCD_MAX);
  end

  assign ptr_bin = 14'(ptr_i[15:12]) * `BTC_W1000
                 + 14'(ptr_i[11:8])  * `BTC_W100
                 + 14'(ptr_i[7:4])   * `BTC_W10
                 + 14'(ptr_i[3:0]);

  // pointer must be BCD and inside data memory
  assign bad_o  = ind_i && ((digit_ok != 4'hF) || (ptr_bin >= `BTC_DM_WORDS));
  assign addr_o = ind_i ? (`BTC_DM_BASE + {2'h0, ptr_bin[9:0]}) : addr_i;

endmodule : btc_ind_resolve

// [btc_pkg.sv]
package btc_pkg;

  // -------------------------------------------------------------------------
  // Sequencer states, one-hot
  // -------------------------------------------------------------------------
  typedef enum logic [8:0] {
    BTC_IDLE = 9'h001,
    BTC_XRS  = 9'h002,
    BTC_XRD  = 9'h004,
    BTC_XWR  = 9'h008,
    BTC_CRA  = 9'h010,
    BTC_CRB  = 9'h020,
    BTC_CCM  = 9'h040,
    BTC_CWR  = 9'h080,
    BTC_DONE = 9'h100
  } btc_state_type;

  typedef logic [2:0] btc_area_type;

endpackage : btc_pkg
